// [verilog/dkc_ctrl.sv]
// Host-side cycle controller for a 4K x 1 dynamic RAM with refresh
module dkc_ctrl #(
   parameter int REF_GAP = dkc_pkg::REF_GAP_CYC   // Cycles between refresh rows
) (
   input  wire logic              clk_i,       // 10 MHz system clock
   input  wire logic              sys_rst_i,   // Synchronous reset, active high
   input  wire logic              req_valid_i, // Request offered
   output logic                   req_ready_o, // Request taken this cycle
   input  wire dkc_pkg::dkc_req_t req_i,       // Operation, address, write bit
   input  wire logic              rmw_data_i,  // New bit written in an RMW
   output logic                   rsp_valid_o, // One-cycle pulse: cycle ended
   output logic                   rsp_data_o,  // Read bit, registered
   output dkc_pkg::dkc_pins_t     pins_o,      // Strobe, select, write, addr, din
   input  wire logic              dout_i       // Memory data output pin
);

   // ****************************************************************
   // Elaboration check
   // ****************************************************************
   // The refresh counter is 16 bits wide, so longer gaps cannot be counted
   if (REF_GAP < 32 || REF_GAP > 65536)
      $error("REF_GAP outside the range the refresh timer can serve");

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_SET  = 6'h02,
      ST_ON   = 6'h04,
      ST_WR   = 6'h08,
      ST_OFF  = 6'h10,
      ST_REF  = 6'h20
   } dkc_state_t;

   dkc_state_t                   state_r, state_nxt;
   dkc_pkg::dkc_req_t            req_r;
   dkc_pkg::dkc_pins_t           pins_r;
   logic [7:0]                   cnt_r;
   logic [15:0]                  ref_cnt_r;
   logic [dkc_pkg::REF_BITS-1:0] row_r;
   logic                         ref_due_r;
   logic                         ref_cyc_r;
   logic                         rsp_valid_r;
   logic                         rsp_data_r;
   logic                         dout_s;

   // Memory output is asynchronous to clk_i
   dkc_sync u_sync (
      .clk_i     (clk_i),
      .sys_rst_i (sys_rst_i),
      .d_i       (dout_i),
      .q_o       (dout_s)
   );

   // ****************************************************************
   // Decodes
   // ****************************************************************
   wire is_write   = (req_r.op == dkc_pkg::DKC_OP_WRITE);
   wire is_rmw     = (req_r.op == dkc_pkg::DKC_OP_RMW);
   wire idle       = (state_r == ST_IDLE);
   // Refresh has priority so the 2 ms bound never slips
   wire take_req   = idle && !ref_due_r && req_valid_i;
   wire start_ref  = idle && ref_due_r;
   // Reads stay on until the access time has crossed both sync flops; the
   // output floats at strobe fall, so the bit must be caught before then
   wire [7:0] rd_len = 8'(dkc_pkg::ACCESS_CYC + 2);
   wire [7:0] on_len = is_rmw   ? 8'(dkc_pkg::RMW_ON_CYC) :
                       is_write ? 8'(dkc_pkg::STROBE_ON_CYC) : rd_len;
   // Cycles left before strobe fall when the RMW write strobe drops: late
   // enough to clear the output delay, early enough for write-to-off
   wire [7:0] wr_at  = 8'(dkc_pkg::WR_TO_OFF_CYC);
   wire cnt_done   = (cnt_r == 8'h00);
   wire ref_tick   = (ref_cnt_r == 16'(REF_GAP - 1));

   assign req_ready_o = take_req;
   assign rsp_valid_o = rsp_valid_r;
   assign rsp_data_o  = rsp_data_r;
   assign pins_o      = pins_r;

   // Next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ST_IDLE: begin
            if (start_ref)     state_nxt = ST_SET;
            else if (take_req) state_nxt = ST_SET;
         end
         ST_SET:  state_nxt = ST_ON;
         ST_ON:   if (cnt_done) state_nxt = ST_OFF;
         ST_OFF:  if (cnt_done) state_nxt = ST_IDLE;
         default: state_nxt = ST_IDLE;
      endcase
   end

   // ****************************************************************
   // Refresh timer
   // ****************************************************************
   // refresh interval bound
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         ref_cnt_r <= 16'h0000;
         ref_due_r <= 1'b0;
      end else begin
         ref_cnt_r <= ref_tick ? 16'h0000 : ref_cnt_r + 16'h0001;
         // Set wins over the clear when both land together
         if (ref_tick)        ref_due_r <= 1'b1;
         else if (start_ref)  ref_due_r <= 1'b0;
      end
   end

   // ****************************************************************
   // Cycle sequencer and pin drive
   // ****************************************************************
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         state_r     <= ST_IDLE;
         req_r       <= '0;
         pins_r      <= '{strobe: 1'b0, sel_n: 1'b1, wr_n: 1'b1, addr: '0, din: 1'b0};
         cnt_r       <= 8'h00;
         row_r       <= '0;
         ref_cyc_r   <= 1'b0;
         rsp_valid_r <= 1'b0;
         rsp_data_r  <= 1'b0;
      end else begin
         state_r     <= state_nxt;
         rsp_valid_r <= 1'b0;
         case (state_r)
            ST_IDLE: begin
               if (start_ref) begin
                  pins_r.addr  <= {{(dkc_pkg::ADDR_W-dkc_pkg::REF_BITS){1'b0}}, row_r};
                  row_r        <= row_r + {{(dkc_pkg::REF_BITS-1){1'b0}}, 1'b1};
                  pins_r.sel_n <= 1'b1;
                  ref_cyc_r    <= 1'b1;
                  req_r.op     <= dkc_pkg::DKC_OP_READ;
               end else if (take_req) begin
                  pins_r.addr  <= req_i.addr;
                  pins_r.sel_n <= 1'b0;
                  pins_r.din   <= req_i.wdata;
                  ref_cyc_r    <= 1'b0;
                  req_r        <= req_i;
               end
            end
            ST_SET: begin
               // address settled one cycle before strobe rise
               pins_r.strobe <= 1'b1;
               cnt_r         <= on_len - 8'h01;
               // early write strobe for plain writes
               if (is_write && !ref_cyc_r) pins_r.wr_n <= 1'b0;
            end
            ST_ON: begin
               cnt_r <= cnt_r - 8'h01;
               // RMW read bit caught once the access time has crossed both sync flops
               if (is_rmw && (on_len - cnt_r) == 8'(dkc_pkg::ACCESS_CYC + 2)) begin
                  rsp_data_r <= dout_s;
               end
               // write strobe low long enough before strobe fall
               // pulse lasts to strobe fall, well past minimum
               if (is_rmw && cnt_r == wr_at) begin
                  pins_r.din  <= rmw_data_i;
                  pins_r.wr_n <= 1'b0;
               end
               if (cnt_done) begin
                  pins_r.strobe <= 1'b0;
                  pins_r.wr_n   <= 1'b1;
                  cnt_r         <= 8'(dkc_pkg::OFF_CYC);
                  // read sampled after access time plus sync delay
                  // Refresh cycles are deselected and must not clobber the last read bit
                  if (req_r.op == dkc_pkg::DKC_OP_READ && !ref_cyc_r) rsp_data_r <= dout_s;
                  rsp_valid_r <= !ref_cyc_r;
               end
            end
            ST_OFF: begin
               // address held through strobe off and beyond hold time
               cnt_r <= cnt_r - 8'h01;
               if (cnt_done) pins_r.sel_n <= 1'b1;
            end
            default: ;
         endcase
      end
   end

endmodule

// [inc/dkc_pkg.sv]
// Package of constants and carrier types for the 4K x 1 dynamic RAM controller
//
// Behaviour
// - Every row is refreshed at intervals no longer than 2 ms.
// - Refresh walks all 64 values of the six low address bits.
// - Address settles before strobe rises and holds at least 50 ns after.
// - In refresh, row and column address stay stable through the hold interval.
// - Write strobe low before strobe rise means data valid at strobe rise.
// - Read-modify-write keeps write strobe high until output delay has passed.
// - Write strobe low at least 180 ns before strobe falls in writes.
// - Each write strobe low pulse lasts at least 70 ns.
// - Active-low chip select gates the data path of one shared device.
package dkc_pkg;

   // ****************************************************************
   // Geometry
   // ****************************************************************
   localparam int ADDR_W     = 12;
   localparam int WORDS      = 4096;
   localparam int REF_BITS   = 6;
   localparam int REF_ROWS   = 64;

   // ****************************************************************
   // Timing in ns, refresh period in ms, slowest grade, and clock rate
   // ****************************************************************
   localparam int CLK_NS           = 100;
   localparam int ADDR_HOLD_NS     = 50;
   localparam int STROBE_OUT_NS    = 280;
   localparam int ACCESS_NS        = 300;
   localparam int STROBE_ON_NS     = 300;
   localparam int RMW_ON_NS        = 480;
   localparam int STROBE_OFF_NS    = 130;
   localparam int WR_TO_OFF_NS     = 180;
   localparam int WR_PULSE_NS      = 70;
   localparam int REF_PERIOD_MS    = 2;

   // Least times round up, longest times round down
   localparam int ADDR_HOLD_CYC  = (ADDR_HOLD_NS + CLK_NS - 1) / CLK_NS;
   localparam int ACCESS_CYC     = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
   localparam int STROBE_ON_CYC  = (STROBE_ON_NS + CLK_NS - 1) / CLK_NS;
   localparam int RMW_ON_CYC     = (RMW_ON_NS + CLK_NS - 1) / CLK_NS;
   localparam int OFF_CYC        = (STROBE_OFF_NS + CLK_NS - 1) / CLK_NS;
   localparam int WR_TO_OFF_CYC  = (WR_TO_OFF_NS + CLK_NS - 1) / CLK_NS;
   localparam int WR_PULSE_CYC   = (WR_PULSE_NS + CLK_NS - 1) / CLK_NS;
   // Per-row spacing so 64 rows fit in the refresh period
   localparam int REF_GAP_CYC    = (REF_PERIOD_MS * 1000000 / CLK_NS) / REF_ROWS;

   // ****************************************************************
   // Operation codes and carriers
   // ****************************************************************
   typedef enum logic [1:0] {
      DKC_OP_READ  = 2'h0,
      DKC_OP_WRITE = 2'h1,
      DKC_OP_RMW   = 2'h2
   } dkc_op_t;

   typedef struct packed {
      dkc_op_t             op;
      logic [ADDR_W-1:0]   addr;
      logic                wdata;
   } dkc_req_t;

   typedef struct packed {
      logic                strobe;
      logic                sel_n;
      logic                wr_n;
      logic [ADDR_W-1:0]   addr;
      logic                din;
   } dkc_pins_t;

endpackage

// [verilog/dkc_sync.sv]
// Two-flop synchroniser for one pin input
module dkc_sync (
   input  wire logic clk_i,        // System clock
   input  wire logic sys_rst_i,    // Synchronous reset, active high
   input  wire logic d_i,          // Asynchronous pin level
   output logic      q_o           // Level in clk_i domain
);

   logic meta_r;
   logic q_r;

   // First stage feeds only the second stage
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         meta_r <= 1'b0;
         q_r    <= 1'b0;
      end else begin
         meta_r <= d_i;
         q_r    <= meta_r;
      end
   end

   assign q_o = q_r;

endmodule

// [tb/dkc_ctrl_props.sv]
// Pin protocol checker for the dynamic RAM cycle controller
module dkc_ctrl_props #(
   parameter int REF_GAP = 64             // Cycles between refresh rows
) (
   input wire logic               clk_i,       // System clock
   input wire logic               sys_rst_i,   // Synchronous reset
   input wire logic               req_valid_i, // Request offered
   input wire logic               req_ready_o, // Request taken
   input wire dkc_pkg::dkc_req_t  req_i,       // Request fields
   input wire logic               rmw_data_i,  // New RMW bit
   input wire logic               rsp_valid_o, // Cycle ended
   input wire logic               rsp_data_o,  // Read bit
   input wire dkc_pkg::dkc_pins_t pins_o,      // Memory pins
   input wire logic               dout_i       // Memory output
);
   logic [31:0] gap_r;
   logic [5:0]  row_r;
   default clocking @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   // Refresh bookkeeping; slack covers a cycle already under way
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         gap_r <= '0;
         row_r <= '0;
      end else if ($rose(pins_o.strobe) && pins_o.sel_n) begin
         gap_r <= '0;
         row_r <= row_r + 6'h01;
      end else begin
         gap_r <= gap_r + 32'h1;
      end
   end
   a_refresh_gap: assert property (gap_r <= 32'(REF_GAP) + 32'h10)
      else $error("refresh row overdue");
   a_refresh_row_walk: assert property ($rose(pins_o.strobe) && pins_o.sel_n |->
      pins_o.addr[5:0] == row_r) else $error("refresh row out of order");
   a_addr_hold: assert property ($rose(pins_o.strobe) |->
      $stable(pins_o.addr) ##1 $stable(pins_o.addr)) else $error("address moved");
   a_din_at_rise: assert property ($rose(pins_o.strobe) && !pins_o.wr_n |->
      $stable(pins_o.din)) else $error("write data not settled");
   a_read_before_write: assert property ($rose(pins_o.strobe) && pins_o.wr_n |->
      pins_o.wr_n [*3]) else $error("write strobe dropped early");
   a_write_lead_time: assert property ($fell(pins_o.strobe) && !$past(pins_o.wr_n) |->
      !$past(pins_o.wr_n, 2)) else $error("write strobe too short before fall");
   a_write_in_cycle: assert property ($fell(pins_o.wr_n) |->
      pins_o.strobe && !pins_o.sel_n) else $error("write strobe outside cycle");
   a_strobe_on_width: assert property ($rose(pins_o.strobe) |->
      pins_o.strobe [*3]) else $error("strobe on time too short");
   a_rsp_on_fall: assert property (rsp_valid_o |->
      $fell(pins_o.strobe) && !pins_o.sel_n) else $error("response off strobe fall");
endmodule

bind dkc_ctrl dkc_ctrl_props #(.REF_GAP(REF_GAP)) i_dkc_ctrl_props (
   .clk_i(clk_i), .sys_rst_i(sys_rst_i), .req_valid_i(req_valid_i),
   .req_ready_o(req_ready_o), .req_i(req_i), .rmw_data_i(rmw_data_i),
   .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o), .pins_o(pins_o), .dout_i(dout_i));

// [tb/dkc_mem_model.sv]
// Behavioural 4K x 1 dynamic RAM answering the controller pins
module dkc_mem_model #(
   parameter int ACC_NS = 290             // Strobe rise to valid data
) (
   input  wire dkc_pkg::dkc_pins_t pins_i, // Controller pins
   output logic                    dout_o  // Data output pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic mem [0:4095];
   logic q = 1'b0;
   logic on = 1'b0;
   initial foreach (mem[i]) mem[i] = 1'b0;
   // full decode, data only late in the access time
   always @(posedge pins_i.strobe) begin
      on = 1'b0;
      #(ACC_NS);
      if (pins_i.strobe && !pins_i.sel_n) begin
         q = mem[pins_i.addr];
         on = 1'b1;
      end
   end
   // selected cycle with write strobe low stores data-in
   always @(posedge pins_i.strobe or negedge pins_i.wr_n) begin
      #1;
      if (pins_i.strobe && !pins_i.sel_n && !pins_i.wr_n) mem[pins_i.addr] = pins_i.din;
   end
   // float at once on strobe fall or deselect
   always @(negedge pins_i.strobe or posedge pins_i.sel_n) on = 1'b0;
   // No pull on the line, so a floating output shows the opposite level
   assign dout_o = on ? q : ~q;
endmodule

// [tb/tb_top.sv]
// Self-checking testbench for the dynamic RAM cycle controller
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int GAP = 64;               // Short refresh spacing gives many refresh cycles within a brief run
   logic               clk_i = 1'b0;
   logic               sys_rst_i = 1'b1;
   logic               req_valid_i = 1'b0;
   logic               rmw_data_i = 1'b0;
   logic               req_ready_o;
   logic               rsp_valid_o;
   logic               rsp_data_o;
   logic               dout_i;
   dkc_pkg::dkc_req_t  req_i = '0;
   dkc_pkg::dkc_pins_t pins_o;
   dkc_pkg::dkc_op_t   op_r;
   logic               shadow [0:4095];
   logic [11:0]        a;
   int                 num_errors = 0;
   int                 checks = 0;
   int                 seed = 32'hB637;

   always #50 clk_i = ~clk_i;

   dkc_ctrl #(.REF_GAP(GAP)) i_dkc_ctrl (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .req_valid_i(req_valid_i), .req_ready_o(req_ready_o), .req_i(req_i),
      .rmw_data_i(rmw_data_i), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
      .pins_o(pins_o), .dout_i(dout_i));
   dkc_mem_model #(.ACC_NS(290)) i_dkc_mem_model (.pins_i(pins_o), .dout_o(dout_i));

   task automatic end_of_test();
      if (num_errors == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      checks++;
      if (got !== exp) begin
         num_errors++;
         $display("BAD %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   // Content of the cell after an operation
   function automatic logic new_bit(input dkc_pkg::dkc_op_t op, input logic old, wd, nb);
      return (op == dkc_pkg::DKC_OP_WRITE) ? wd : (op == dkc_pkg::DKC_OP_RMW) ? nb : old;
   endfunction

   // Cycles from the take edge to the response: one setup cycle plus strobe-on time
   function automatic logic [7:0] exp_lat(input dkc_pkg::dkc_op_t op);
      if (op == dkc_pkg::DKC_OP_WRITE) return 8'(1 + dkc_pkg::STROBE_ON_CYC);
      if (op == dkc_pkg::DKC_OP_RMW) return 8'(1 + dkc_pkg::RMW_ON_CYC);
      // Reads also wait out the two-flop lag on the data pin
      return 8'(1 + dkc_pkg::ACCESS_CYC + 2);
   endfunction

   // Request held until taken, then bounded wait for the response pulse
   task automatic run_op(input dkc_pkg::dkc_op_t op, input logic [11:0] ad, input logic wd, nb);
      int k;
      k = 0;
      @(negedge clk_i);
      req_i = '{op: op, addr: ad, wdata: wd};
      rmw_data_i = nb;
      req_valid_i = 1'b1;
      #1;
      while (req_ready_o !== 1'b1 && k < 100) begin
         @(negedge clk_i);
         #1;
         k++;
      end
      @(negedge clk_i);
      req_valid_i = 1'b0;
      k = 0;
      while (rsp_valid_o !== 1'b1 && k < 100) begin
         @(negedge clk_i);
         k++;
      end
      cmp("latency", exp_lat(op), 8'(k));
      if (op != dkc_pkg::DKC_OP_WRITE) cmp("read bit", {7'h0, shadow[ad]}, {7'h0, rsp_data_o});
      shadow[ad] = new_bit(op, shadow[ad], wd, nb);
   endtask

   initial begin
      foreach (shadow[i]) shadow[i] = 1'b0;
      repeat (20) @(negedge clk_i);
      sys_rst_i = 1'b0;
      // Array ends, read-modify-write and readback
      run_op(dkc_pkg::DKC_OP_WRITE, 12'h000, 1'b1, 1'b0);
      run_op(dkc_pkg::DKC_OP_WRITE, 12'hFFF, 1'b1, 1'b0);
      run_op(dkc_pkg::DKC_OP_READ, 12'h7FF, 1'b1, 1'b1);
      run_op(dkc_pkg::DKC_OP_RMW, 12'hFFF, 1'b0, 1'b0);
      run_op(dkc_pkg::DKC_OP_READ, 12'hFFF, 1'b1, 1'b1);
      // Reset in mid-run must park the pins idle
      @(negedge clk_i);
      sys_rst_i = 1'b1;
      repeat (3) @(negedge clk_i);
      cmp("reset pins", 8'h01, {6'h0, pins_o.strobe, pins_o.sel_n});
      sys_rst_i = 1'b0;
      // Random traffic over a small address set so cells are revisited
      for (int i = 0; i < 300; i++) begin
         a = 12'($random(seed)) & 12'h83F;
         op_r = dkc_pkg::dkc_op_t'(2'($unsigned($random(seed)) % 3));
         run_op(op_r, a, 1'($random(seed)), 1'($random(seed)));
         repeat ($unsigned($random(seed)) % 3) @(negedge clk_i);
      end
      end_of_test();
   end

   // Watchdog well beyond the expected run length
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      end_of_test();
   end
endmodule
